// [hw/flash_ovl_pkg.sv]
// Constants for the flash overlay and vector redirect register bank.
// Assumes an 8-bit register port and a 24-bit processor address.
package flash_ovl_pkg;
   localparam int ADDR_W = 24;
   localparam int REG_AW = 4;

   // Register offsets (chosen, no offsets are given)
   localparam logic [3:0] OFF_OVL_SEL   = 4'h0;
   localparam logic [3:0] OFF_VEC_CTRL  = 4'h1;
   localparam logic [3:0] OFF_VEC_B3    = 4'h2;
   localparam logic [3:0] OFF_VEC_B2    = 4'h3;
   localparam logic [3:0] OFF_VEC_B1    = 4'h4;
   localparam logic [3:0] OFF_VEC_B0    = 4'h5;
   localparam logic [3:0] OFF_ERASE_ST  = 4'h6;
   localparam logic [3:0] OFF_IRQ_STAT  = 4'h7;
   localparam logic [3:0] OFF_IRQ_EN    = 4'h8;
   localparam logic [3:0] OFF_IRQ_CLR   = 4'h9;

   // Field positions
   localparam int OVL_EN_BIT    = 3;
   localparam int OVL_SEL_LSB   = 0;
   localparam int OVL_SEL_W     = 3;
   localparam int REDIR_EN_BIT  = 7;
   localparam int FAIL_BIT      = 0;
   localparam int IRQ_DONE_BIT  = 0;
   localparam int IRQ_FAIL_BIT  = 1;
   localparam int IRQ_W         = 2;

   // Reset values
   localparam logic [7:0]  OVL_SEL_RST  = 8'h00;
   localparam logic [7:0]  VEC_CTRL_RST = 8'h00;
   localparam logic [31:0] VEC_ADDR_RST = 32'h0000_0000;

   // Address map
   localparam logic [23:0] RAM_WIN_BASE  = 24'hFF_D000;
   localparam logic [23:0] FLASH_BASE    = 24'h00_0000;
   localparam int          BLOCK_BITS    = 12;
   localparam logic [23:0] NMI_VEC_ADDR  = 24'h00_001C;
endpackage : flash_ovl_pkg

// [hw/ovl_map.sv]
// Address remap for the RAM overlay.
// Assumes the processor address is stable in the cycle it is presented.
`timescale 1ns/1ps
module ovl_map
   import flash_ovl_pkg::*;
#(
   parameter int AW = ADDR_W
) (
   // Control
   input  wire logic          ovl_on,
   input  wire logic [2:0]    blk_sel,
   // Address
   input  wire logic [AW-1:0] addr_in,
   output logic      [AW-1:0] addr_out,
   output logic               hit
);
   logic [AW-1:0] blk_base;

   always_comb begin
      blk_base = AW'(FLASH_BASE)
         | (AW'(blk_sel) << BLOCK_BITS);
      hit      = ovl_on && (addr_in[AW-1:BLOCK_BITS]
                 == blk_base[AW-1:BLOCK_BITS]);
      // Offset inside the block is kept
      addr_out = hit ? (AW'(RAM_WIN_BASE)
         | {{(AW-BLOCK_BITS){1'b0}}, addr_in[BLOCK_BITS-1:0]})
         : addr_in;
   end
endmodule : ovl_map

// [hw/flash_ovl_regs.sv]
// Register bank: RAM overlay select, NMI vector redirect, erase flag.
// Assumes synchronous register strobes; reset covers power-on and
// hardware standby, software standby leaves the clock gated only.
//
// Function
// - erase outcome flag bit0, one means error
// - overlay select cleared by reset, kept otherwise
// - reserved bits read zero, written zero
// - overlay enable sets emulation, protects boot array
// - overlay off: no emulation, no protection
// - block select n picks block n*4096
// - redirect control cleared by reset
// - redirect off: vector from low memory
// - redirect on: vector from vector register
// - 32-bit vector register cleared by reset
// - four byte registers map vector bytes
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module flash_ovl_regs
   import flash_ovl_pkg::*;
#(
   parameter int AW = ADDR_W
) (
   // Clock and reset
   input  wire logic          SYS_CLK,
   input  wire logic          ARST_N,
   // Register port
   input  wire logic [3:0]    REG_ADDR,
   input  wire logic [7:0]    REG_WDATA,
   input  wire logic          REG_WR,
   input  wire logic          REG_RD,
   output logic      [7:0]    REG_RDATA,
   // Erase sequencer result
   input  wire logic          ERASE_DONE,
   input  wire logic          ERASE_FAILED,
   // Processor address path
   input  wire logic [AW-1:0] CPU_ADDR,
   output logic      [AW-1:0] MAPPED_ADDR,
   output logic               OVL_HIT,
   // Flash control
   output logic               EMUL_ON,
   output logic               BOOT_PROTECT,
   // NMI vector source
   output logic               VEC_FROM_REG,
   output logic      [31:0]   NMI_VECTOR,
   output logic      [AW-1:0] NMI_VEC_FETCH_ADDR,
   // Interrupt
   output logic               IRQ
);
   // The remap and the fixed vector slot need at least 24 address bits
   if (AW < ADDR_W || AW > 32) begin : g_bad_aw
      $error("AW out of range");
   end

   logic [3:0]        ovl_sel_r,   ovl_sel_nxt;
   logic              redir_en_r,  redir_en_nxt;
   logic [31:0]       vec_r,       vec_nxt;
   logic              fail_r,      fail_nxt;
   logic [IRQ_W-1:0]  irq_st_r,    irq_st_nxt;
   logic [IRQ_W-1:0]  irq_en_r,    irq_en_nxt;
   logic [7:0]        rdata_r,     rdata_nxt;
   logic              wr_ovl;
   logic              wr_ctrl;
   logic              wr_clr;
   logic              wr_en;

   always_comb begin
      wr_ovl  = REG_WR && (REG_ADDR == OFF_OVL_SEL);
      wr_ctrl = REG_WR && (REG_ADDR == OFF_VEC_CTRL);
      wr_clr  = REG_WR && (REG_ADDR == OFF_IRQ_CLR);
      wr_en   = REG_WR && (REG_ADDR == OFF_IRQ_EN);

      ovl_sel_nxt  = ovl_sel_r;
      redir_en_nxt = redir_en_r;
      vec_nxt      = vec_r;
      fail_nxt     = fail_r;
      irq_en_nxt   = irq_en_r;

      if (wr_ovl) begin
         ovl_sel_nxt = REG_WDATA[3:0];
      end
      if (wr_ctrl) begin
         redir_en_nxt = REG_WDATA[REDIR_EN_BIT];
      end
      if (REG_WR) begin
         case (REG_ADDR)
            OFF_VEC_B3: vec_nxt[31:24] = REG_WDATA;
            OFF_VEC_B2: vec_nxt[23:16] = REG_WDATA;
            OFF_VEC_B1: vec_nxt[15:8]  = REG_WDATA;
            OFF_VEC_B0: vec_nxt[7:0]   = REG_WDATA;
            default: ;
         endcase
      end
      if (wr_en) begin
         irq_en_nxt = REG_WDATA[IRQ_W-1:0];
      end
      // Flag stays writable; a sequencer result overrides the write
      if (REG_WR && REG_ADDR == OFF_ERASE_ST) begin
         fail_nxt = REG_WDATA[FAIL_BIT];
      end
      if (ERASE_DONE) begin
         fail_nxt = ERASE_FAILED;
      end

      // Set wins over a clear in the same cycle
      irq_st_nxt = irq_st_r;
      if (wr_clr) begin
         irq_st_nxt = irq_st_r & ~REG_WDATA[IRQ_W-1:0];
      end
      irq_st_nxt[IRQ_DONE_BIT] = irq_st_nxt[IRQ_DONE_BIT] | ERASE_DONE;
      irq_st_nxt[IRQ_FAIL_BIT] = irq_st_nxt[IRQ_FAIL_BIT]
                                 | (ERASE_DONE & ERASE_FAILED);

      rdata_nxt = 8'h00;
      if (REG_RD) begin
         case (REG_ADDR)
            OFF_OVL_SEL:  rdata_nxt = {4'h0, ovl_sel_r};
            OFF_VEC_CTRL: rdata_nxt = {redir_en_r, 7'h00};
            OFF_VEC_B3:   rdata_nxt = vec_r[31:24];
            OFF_VEC_B2:   rdata_nxt = vec_r[23:16];
            OFF_VEC_B1:   rdata_nxt = vec_r[15:8];
            OFF_VEC_B0:   rdata_nxt = vec_r[7:0];
            OFF_ERASE_ST: rdata_nxt = {7'h00, fail_r};
            OFF_IRQ_STAT: rdata_nxt = {6'h00, irq_st_r};
            OFF_IRQ_EN:   rdata_nxt = {6'h00, irq_en_r};
            default:      rdata_nxt = 8'h00;
         endcase
      end
   end

   // Reset here stands for power-on and hardware standby alike
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ovl_sel_r  <= OVL_SEL_RST[3:0];
         redir_en_r <= VEC_CTRL_RST[REDIR_EN_BIT];
         vec_r      <= VEC_ADDR_RST;
         fail_r     <= 1'b0;
         irq_st_r   <= '0;
         irq_en_r   <= '0;
         rdata_r    <= 8'h00;
      end else begin
         ovl_sel_r  <= ovl_sel_nxt;
         redir_en_r <= redir_en_nxt;
         vec_r      <= vec_nxt;
         fail_r     <= fail_nxt;
         irq_st_r   <= irq_st_nxt;
         irq_en_r   <= irq_en_nxt;
         rdata_r    <= rdata_nxt;
      end
   end

   ovl_map #(
      .AW (AW)
   ) u_map (
      .ovl_on   (ovl_sel_r[OVL_EN_BIT]),
      .blk_sel  (ovl_sel_r[OVL_SEL_LSB +: OVL_SEL_W]),
      .addr_in  (CPU_ADDR),
      .addr_out (MAPPED_ADDR),
      .hit      (OVL_HIT)
   );

   always_comb begin
      REG_RDATA    = rdata_r;
      EMUL_ON      = ovl_sel_r[OVL_EN_BIT];
      BOOT_PROTECT = ovl_sel_r[OVL_EN_BIT];
      VEC_FROM_REG = redir_en_r;
      NMI_VECTOR   = vec_r;
      // Fixed low-memory vector slot used while redirect is off
      NMI_VEC_FETCH_ADDR = AW'(NMI_VEC_ADDR);
      IRQ          = |(irq_st_r & irq_en_r);
   end
endmodule : flash_ovl_regs

// [bench/flash_ovl_regs_assertions.sv]
// Port checker for flash_ovl_regs.
// Assumes one clock domain and an active-low async reset.
`timescale 1ns/1ps
module flash_ovl_regs_assertions
   import flash_ovl_pkg::*;
#(parameter int AW = ADDR_W) (
   // Clock, reset and register port
   input wire logic          SYS_CLK,
   input wire logic          ARST_N,
   input wire logic [3:0]    REG_ADDR,
   input wire logic [7:0]    REG_WDATA,
   input wire logic          REG_WR,
   input wire logic          REG_RD,
   input wire logic [7:0]    REG_RDATA,
   // Address path and controls
   input wire logic [AW-1:0] CPU_ADDR,
   input wire logic [AW-1:0] MAPPED_ADDR,
   input wire logic          OVL_HIT,
   input wire logic          EMUL_ON,
   input wire logic          BOOT_PROTECT,
   input wire logic          VEC_FROM_REG,
   input wire logic [AW-1:0] NMI_VEC_FETCH_ADDR
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);
   wire w0 = REG_WR && REG_ADDR == OFF_OVL_SEL;
   wire wv = REG_WR && REG_ADDR == OFF_VEC_CTRL;
   AST_OVL_RSV:
   assert property (REG_RD && REG_ADDR == OFF_OVL_SEL |=> REG_RDATA[7:4] == 4'h0)
      else $error("overlay reserved bits read nonzero");
   AST_CTRL_RSV:
   assert property (REG_RD && REG_ADDR == OFF_VEC_CTRL |=> REG_RDATA[6:0] == 0)
      else $error("redirect reserved bits read nonzero");
   AST_OVL_ON:
   assert property (w0 && REG_WDATA[3] |=> EMUL_ON && BOOT_PROTECT)
      else $error("overlay enable write not applied");
   AST_OVL_OFF:
   assert property (w0 && !REG_WDATA[3] |=> !EMUL_ON && !BOOT_PROTECT)
      else $error("overlay disable write not applied");
   AST_HOLD:
   assert property (!w0 |=> $stable(EMUL_ON))
      else $error("overlay enable changed without write");
   AST_HIT:
   assert property (OVL_HIT |-> EMUL_ON && CPU_ADDR[23:15] == 0 &&
      MAPPED_ADDR == {RAM_WIN_BASE[23:12], CPU_ADDR[11:0]})
      else $error("overlay hit maps wrongly");
   AST_NO_OVL:
   assert property (!EMUL_ON |-> !OVL_HIT && MAPPED_ADDR == CPU_ADDR)
      else $error("address altered with overlay off");
   AST_REDIR:
   assert property (wv && REG_WDATA[7] |=> VEC_FROM_REG)
      else $error("redirect enable not applied");
   AST_FETCH:
   assert property (NMI_VEC_FETCH_ADDR == NMI_VEC_ADDR)
      else $error("vector fetch address wrong");
   AST_RST:
   assert property ($rose(ARST_N) |-> !EMUL_ON && !VEC_FROM_REG)
      else $error("controls not cleared by reset");
   COV_HIT: cover property (OVL_HIT);
   COV_REDIR: cover property ($rose(VEC_FROM_REG));
   COV_WR_RD: cover property (REG_WR ##1 REG_RD);
endmodule : flash_ovl_regs_assertions

// [bench/flash_ram_overlay_vector_redirect_bench.sv]
// Self-checking bench for flash_ovl_regs.
// Assumes the package offsets; drives every design input itself.
`timescale 1ns/1ps
module flash_ram_overlay_vector_redirect_bench
   import flash_ovl_pkg::*;
;
   logic        SYS_CLK = 0, ARST_N = 0, REG_WR = 0, REG_RD = 0;
   logic        ERASE_DONE = 0, ERASE_FAILED = 0, OVL_HIT, EMUL_ON, IRQ;
   logic        BOOT_PROTECT, VEC_FROM_REG;
   logic [3:0]  REG_ADDR = 4'h0;
   logic [7:0]  REG_WDATA = 8'h00, REG_RDATA, q;
   logic [23:0] CPU_ADDR = 24'h00_0000, MAPPED_ADDR, NMI_VEC_FETCH_ADDR;
   logic [31:0] NMI_VECTOR;
   int          n_errors = 0, checks_done = 0, cyc = 0;
   // Row: offset, write value, expected read back (last is unmapped)
   localparam logic [19:0] ROWS [7] = '{20'h0_FB0B, 20'h1_FF80, 20'h2_1212,
      20'h3_3434, 20'h4_5656, 20'h5_7878, 20'hF_AA00};
   flash_ovl_regs u_dut (.*);
   initial forever #25 SYS_CLK = ~SYS_CLK;
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge SYS_CLK);
      REG_ADDR  <= a;
      REG_WDATA <= d;
      REG_WR    <= 1'b1;
      @(posedge SYS_CLK);
      REG_WR    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge SYS_CLK);
      REG_ADDR <= a;
      REG_RD   <= 1'b1;
      @(posedge SYS_CLK);
      REG_RD   <= 1'b0;
      #1 q = REG_RDATA;
   endtask : rd
   task automatic erase(input logic f);
      @(posedge SYS_CLK);
      ERASE_DONE   <= 1'b1;
      ERASE_FAILED <= f;
      @(posedge SYS_CLK);
      ERASE_DONE   <= 1'b0;
   endtask : erase
   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   // The whole run needs some 80 cycles
   always @(posedge SYS_CLK) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         finish_test;
      end
   end
   initial begin
      repeat (10) @(posedge SYS_CLK);
      ARST_N <= 1'b1;
      chk("vector", NMI_VECTOR, 32'h0000_0000);
      // Bench writes and reads back each row with interrupts masked
      foreach (ROWS[i]) begin
         wr(ROWS[i][19:16], ROWS[i][15:8]);
         rd(ROWS[i][19:16]);
         chk("reg", q, 32'(ROWS[i][7:0]));
      end
      chk("vector", NMI_VECTOR, 32'h1234_5678);
      chk("redir", VEC_FROM_REG, 1'b1);
      chk("fetch", NMI_VEC_FETCH_ADDR, NMI_VEC_ADDR);
      for (int n = 0; n < 8; n++) begin
         wr(OFF_OVL_SEL, 8'h08 | 8'(n));
         // Only the map and boot protection are watched here, no real access follows
         CPU_ADDR <= 24'(n * 4096 + 12'h123);
         #1 chk("hit", OVL_HIT, 1'b1);
         chk("map", MAPPED_ADDR, 24'hFF_D123);
         chk("prot", BOOT_PROTECT, 1'b1);
         @(posedge SYS_CLK);
         CPU_ADDR <= 24'((n ^ 1) * 4096 + 12'h123);
         #1 chk("miss", OVL_HIT, 1'b0);
      end
      wr(OFF_OVL_SEL, 8'h07);
      CPU_ADDR <= 24'h00_7123;
      #1 chk("emul", EMUL_ON, 1'b0);
      chk("off", {OVL_HIT, BOOT_PROTECT}, 2'b00);
      chk("pass", MAPPED_ADDR, 24'h00_7123);
      wr(OFF_IRQ_EN, 8'h03);
      erase(1'b1);
      rd(OFF_ERASE_ST);
      chk("fail", q, 8'h01);
      chk("irq", IRQ, 1'b1);
      wr(OFF_IRQ_CLR, 8'h03);
      #1 chk("irqclr", IRQ, 1'b0);
      wr(OFF_IRQ_EN, 8'h00);
      erase(1'b0);
      rd(OFF_ERASE_ST);
      chk("ok", q, 8'h00);
      rd(OFF_IRQ_STAT);
      chk("stat", q, 8'h01);
      chk("mask", IRQ, 1'b0);
      @(posedge SYS_CLK);
      ARST_N <= 1'b0;
      #1 chk("rst", NMI_VECTOR, 32'h0000_0000);
      chk("rst", {VEC_FROM_REG, EMUL_ON}, 2'b00);
      finish_test;
   end
endmodule : flash_ram_overlay_vector_redirect_bench
bind flash_ovl_regs flash_ovl_regs_assertions #(.AW(AW)) u_chk (.*);
